// ==== design/tw_port.sv ====
// two-wire bus port: master engine, slave engine, pin routing, synchronisers
// assumes open-drain pads resolve the oe outputs; pads only ever pull low
// Function
// (RULE1) master and slave logic are separate engines sharing only the pins
// (RULE2) 7-bit and 10-bit addresses: sent as bytes, matched by the slave
// (RULE3) slave recognises the general call address when enabled
// (RULE4) slave holds the clock low until transmit data is supplied
// (RULE5) bit timing follows the standard or the fast bus rate
// (RULE6) master detects lost arbitration and releases the bus
// (RULE7) repeater mode makes the slave accept every address
// (RULE8) route bit at zero moves clock and data to the alternate pins
// (RULE9) master begins a transaction with a start condition
// (RULE10) master sends address with write bit; addressed slave acknowledges
// (RULE11) master samples and reports the acknowledge after each sent byte
// (RULE12) master keeps sending bytes with acknowledge checks until all are sent
// (RULE13) repeated start, then address with read bit, turns the direction
// (RULE14) master receives a byte then drives acknowledge or not-acknowledge
// (RULE15) master ends the transaction with a stop condition
// (RULE16) slave address compare ignores masked bit positions
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.svh"
module tw_port
    import tw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       alt_pin_route_bit,
    input  wire logic       pri_scl_in,
    output logic            pri_scl_out,
    output logic            pri_scl_oe,
    input  wire logic       pri_sda_in,
    output logic            pri_sda_out,
    output logic            pri_sda_oe,
    input  wire logic       alt_serial_clock_pin_in,
    output logic            alt_serial_clock_pin_out,
    output logic            alt_serial_clock_pin_oe,
    input  wire logic       alt_serial_data_pin_in,
    output logic            alt_serial_data_pin_out,
    output logic            alt_serial_data_pin_oe,
    input  wire logic       fast_mode,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    input  wire tw_req_t    cmd,
    output logic            rsp_valid,
    output tw_rsp_t         rsp,
    output logic            bus_owned,
    input  wire tw_scfg_t   scfg,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            addressed,
    output logic            general_call
);
    tw_mstate_t s;
    tw_mstate_t next_s;
    tw_line_t   line;
    logic [1:0] raw;
    logic [5:0] qtr;
    logic       adv;
    logic       lose;
    logic       slv_scl_oe;
    logic       slv_sda_oe;
    logic       scl_drive;
    logic       sda_drive;

    // the mux sits before the synchroniser so only one path is ever sampled
    assign raw = alt_pin_route_bit ? {pri_scl_in, pri_sda_in}
                                   : {alt_serial_clock_pin_in, alt_serial_data_pin_in}; // see (RULE8)

    tw_pin_sync #(.W(2)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (raw),
        .q     (line)
    );

    tw_slave u_slave ( // see (RULE1)
        .clk          (clk),
        .rst_n        (rst_n),
        .line         (line),
        .cfg          (scfg),
        .tx_valid     (tx_valid),
        .tx_data      (tx_data),
        .tx_ready     (tx_ready),
        .rx_valid     (rx_valid),
        .rx_data      (rx_data),
        .addressed    (addressed),
        .general_call (general_call),
        .scl_oe       (slv_scl_oe),
        .sda_oe       (slv_sda_oe)
    );

    assign qtr = fast_mode ? 6'(`TW_FST_QTR) : 6'(`TW_STD_QTR); // see (RULE5)
    // a released clock only advances once the line is high: honours stretching
    assign adv = (s.cnt == 6'h00) && (s.scl_oe || line.scl);

    always_comb begin
        next_s = s;
        lose = 1'b0;
        next_s.rsp_valid = 1'b0;
        if (s.cnt != 6'h00) begin
            next_s.cnt = s.cnt - 6'h01;
        end
        case (s.st)
            M_IDLE: begin
                if (cmd_valid) begin
                    next_s.op = cmd.op;
                    next_s.q = 2'b00;
                    next_s.cnt = qtr;
                    next_s.bits = 4'h0;
                    next_s.rn = cmd.nack;
                    next_s.rsp = '0;
                    // write: byte then a released slot; read: released byte then our ack
                    next_s.sh = (cmd.op == C_READ) ? {8'hFF, cmd.nack}
                                                   : {cmd.data, 1'b1}; // see (RULE2) (RULE10)
                    case (cmd.op)
                        C_START: begin
                            next_s.st = M_START;
                        end
                        C_STOP: begin
                            next_s.st = s.owned ? M_STOP : M_DONE;
                        end
                        default: begin
                            // no byte without owning the bus
                            next_s.st = s.owned ? M_BIT : M_DONE;
                            next_s.rsp.nack = !s.owned;
                        end
                    endcase
                end
            end
            M_START: begin
                if (adv) begin
                    next_s.q = s.q + 2'b01;
                    next_s.cnt = qtr;
                    case (s.q)
                        2'b00: begin
                            next_s.sda_oe = 1'b0; // see (RULE13)
                        end
                        2'b01: begin
                            next_s.scl_oe = 1'b0;
                        end
                        2'b10: begin
                            // data already low means another master holds the bus
                            lose = !line.sda; // see (RULE6)
                            next_s.sda_oe = 1'b1; // see (RULE9)
                        end
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.owned = 1'b1;
                            next_s.st = M_DONE;
                        end
                    endcase
                end
            end
            M_BIT: begin
                if (adv) begin
                    next_s.q = s.q + 2'b01;
                    next_s.cnt = qtr;
                    case (s.q)
                        2'b00: begin
                            next_s.sda_oe = ~s.sh[8]; // see (RULE14)
                        end
                        2'b01: begin
                            next_s.scl_oe = 1'b0;
                        end
                        2'b10: begin
                            if (s.bits[3]) begin
                                next_s.rsp.nack = line.sda; // see (RULE11)
                            end else begin
                                next_s.rsp.data = {s.rsp.data[6:0], line.sda}; // see (RULE14)
                            end
                            lose = s.op == C_WRITE && !s.bits[3]
                                   && s.sh[8] && !line.sda; // see (RULE6)
                        end
                        default: begin
                            next_s.scl_oe = 1'b1;
                            next_s.bits = s.bits + 4'h1;
                            next_s.sh = {s.sh[7:0], 1'b1};
                            if (s.bits == `TW_LAST_BIT) begin
                                next_s.st = M_DONE; // see (RULE12)
                            end
                        end
                    endcase
                end
            end
            M_STOP: begin
                if (adv) begin
                    next_s.q = s.q + 2'b01;
                    next_s.cnt = qtr;
                    case (s.q)
                        2'b00: begin
                            next_s.sda_oe = 1'b1;
                        end
                        2'b01: begin
                            next_s.scl_oe = 1'b0;
                        end
                        2'b10: begin
                            next_s.sda_oe = 1'b1;
                        end
                        default: begin
                            next_s.sda_oe = 1'b0; // see (RULE15)
                            next_s.owned = 1'b0;
                            next_s.st = M_DONE;
                        end
                    endcase
                end
            end
            M_DONE: begin
                next_s.rsp_valid = 1'b1;
                next_s.st = M_IDLE;
            end
            default: begin
                next_s.st = M_IDLE;
            end
        endcase
        if (lose) begin
            next_s.st = M_DONE;
            next_s.scl_oe = 1'b0;
            next_s.sda_oe = 1'b0;
            next_s.owned = 1'b0;
            next_s.rsp.arb_lost = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign scl_drive = s.scl_oe | slv_scl_oe;
    assign sda_drive = s.sda_oe | slv_sda_oe;
    assign pri_scl_out = 1'b0;
    assign pri_sda_out = 1'b0;
    assign alt_serial_clock_pin_out = 1'b0;
    assign alt_serial_data_pin_out = 1'b0;
    assign pri_scl_oe = alt_pin_route_bit & scl_drive; // see (RULE8)
    assign pri_sda_oe = alt_pin_route_bit & sda_drive;
    assign alt_serial_clock_pin_oe = !alt_pin_route_bit & scl_drive;
    assign alt_serial_data_pin_oe = !alt_pin_route_bit & sda_drive;
    assign cmd_ready = (s.st == M_IDLE);
    assign rsp_valid = s.rsp_valid;
    assign rsp = s.rsp;
    assign bus_owned = s.owned;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence stop_tail;
        !s.sda_oe && !s.scl_oe && !s.owned ##1 rsp_valid;
    endsequence

    chk_start_cond: assert property ( // see (RULE9)
        s.st == M_START && s.q == 2'b10 && adv && line.sda |=> s.sda_oe && !s.scl_oe)
        else $error("start: data not pulled while clock high");
    chk_restart_low: assert property ( // see (RULE13)
        s.st == M_START && s.owned && s.q == 2'b00 |-> s.scl_oe)
        else $error("repeated start let the clock rise early");
    chk_stop_cond: assert property ( // see (RULE15)
        s.st == M_STOP && s.q == 2'b11 && adv |=> stop_tail)
        else $error("stop did not release the bus");
    chk_arb_lost: assert property ( // see (RULE6)
        s.st == M_BIT && s.q == 2'b10 && adv && s.op == C_WRITE && !s.bits[3]
        && s.sh[8] && !line.sda |=> s.rsp.arb_lost && !s.sda_oe ##1 rsp_valid)
        else $error("lost arbitration not reported");
    chk_ack_seen: assert property ( // see (RULE11)
        s.st == M_BIT && s.bits == 4'h8 && s.q == 2'b10 && adv
        |=> s.rsp.nack == $past(line.sda))
        else $error("acknowledge slot not recorded");
    chk_rd_ack: assert property ( // see (RULE14)
        s.st == M_BIT && s.op == C_READ && s.bits == 4'h8 && s.q == 2'b10
        |-> s.sda_oe == !s.rn)
        else $error("read acknowledge level wrong");
    chk_byte_len: assert property ( // see (RULE12)
        s.st == M_DONE && $past(s.st) == M_BIT |-> $past(s.bits) == 4'h8 || s.rsp.arb_lost)
        else $error("byte did not span nine bits");
    chk_bit_rate: assert property ( // see (RULE5)
        s.st == M_BIT && adv |=> s.cnt == (fast_mode ? 6'h0D : 6'h32))
        else $error("quarter bit count wrong");
    chk_pin_route: assert property ( // see (RULE8)
        !alt_pin_route_bit |-> !pri_scl_oe && !pri_sda_oe
        && alt_serial_clock_pin_oe == scl_drive)
        else $error("pins not moved to the alternate pair");
endmodule
`default_nettype wire

// ==== design/tw_regs.svh ====
// constants of the two-wire port: bit timing and fixed address patterns
// assumes a 50 ns system clock
`ifndef TW_REGS_SVH
`define TW_REGS_SVH
`define TW_CLK_NS     50
`define TW_STD_QTR_NS 2500
`define TW_FST_QTR_NS 625
`define TW_STD_QTR    ((`TW_STD_QTR_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_FST_QTR    ((`TW_FST_QTR_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`define TW_GC_ADDR    8'h00
`define TW_HDR10      5'h1E
`define TW_LAST_BIT   4'h8
`define TW_TX_LAST    4'h7
`endif

// ==== design/tw_pkg.sv ====
// types shared by the two-wire port modules
// assumes tw_regs.svh holds the numeric constants
package tw_pkg;
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_START = 3'b001,
        M_BIT   = 3'b010,
        M_STOP  = 3'b011,
        M_DONE  = 3'b100
    } tw_mst_t;
    typedef enum logic [1:0] {
        C_START = 2'b00,
        C_WRITE = 2'b01,
        C_READ  = 2'b10,
        C_STOP  = 2'b11
    } tw_cmd_t;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ADDR  = 3'b001,
        S_ADDR2 = 3'b010,
        S_ACK   = 3'b011,
        S_RX    = 3'b100,
        S_LOAD  = 3'b101,
        S_TX    = 3'b110,
        S_RACK  = 3'b111
    } tw_slv_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } tw_line_t;
    typedef struct packed {
        tw_cmd_t    op;
        logic [7:0] data;
        logic       nack;
    } tw_req_t;
    typedef struct packed {
        logic [7:0] data;
        logic       nack;
        logic       arb_lost;
    } tw_rsp_t;
    typedef struct packed {
        logic [9:0] addr;
        logic [9:0] mask;
        logic       ten;
        logic       gc_en;
        logic       repeater;
    } tw_scfg_t;
    typedef struct packed {
        tw_mst_t    st;
        tw_cmd_t    op;
        logic [1:0] q;
        logic [5:0] cnt;
        logic [3:0] bits;
        logic [8:0] sh;
        logic       rn;
        logic       owned;
        logic       scl_oe;
        logic       sda_oe;
        tw_rsp_t    rsp;
        logic       rsp_valid;
    } tw_mstate_t;
    typedef struct packed {
        tw_slv_t    st;
        tw_slv_t    nxt;
        logic [3:0] bits;
        logic [7:0] sh;
        logic       hit;
        logic       gc;
        logic       nk;
        logic       pscl;
        logic       psda;
        logic       scl_oe;
        logic       sda_oe;
        logic       rx_valid;
        logic [7:0] rx_data;
    } tw_sstate_t;
endpackage

// ==== design/tw_pin_sync.sv ====
// three-stage synchroniser for bus pins; output moves once stages two and three agree
// assumes idle bus lines read high
`timescale 1ns/1ps
`default_nettype none
module tw_pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } tw_sync_t;
    tw_sync_t s;
    tw_sync_t next_s;
    always_comb begin
        next_s = s;
        next_s.s1 = d;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.o = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.o);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end
    assign q = s.o;
endmodule
`default_nettype wire

// ==== design/tw_slave.sv ====
// slave engine of the two-wire port: address match, receive, transmit, stretch
// assumes synchronised bus lines; open-drain drive through the oe outputs
`timescale 1ns/1ps
`default_nettype none
`include "tw_regs.svh"
module tw_slave
    import tw_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire tw_line_t   line,
    input  wire tw_scfg_t   cfg,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            addressed,
    output logic            general_call,
    output logic            scl_oe,
    output logic            sda_oe
);
    tw_sstate_t s;
    tw_sstate_t next_s;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic m7;
    logic hdr;
    logic gc;

    // masked bits never block a match
    function automatic logic amatch(input logic [9:0] a, input logic [9:0] b,
                                    input logic [9:0] m);
        amatch = ((a ^ b) & ~m) == 10'h000;
    endfunction

    assign rise = line.scl & ~s.pscl;
    assign fall = ~line.scl & s.pscl;
    assign start_c = line.scl & s.pscl & s.psda & ~line.sda;
    assign stop_c = line.scl & s.pscl & ~s.psda & line.sda;
    assign m7 = !cfg.ten && amatch({cfg.addr[9:7], s.sh[7:1]}, cfg.addr, cfg.mask); // see (RULE16)
    assign hdr = cfg.ten && s.sh[7:3] == `TW_HDR10
                 && amatch({s.sh[2:1], cfg.addr[7:0]}, cfg.addr, cfg.mask); // see (RULE2)
    assign gc = cfg.gc_en && s.sh == `TW_GC_ADDR; // see (RULE3)

    always_comb begin
        next_s = s;
        next_s.pscl = line.scl;
        next_s.psda = line.sda;
        next_s.rx_valid = 1'b0;
        if (start_c) begin
            next_s.st = S_ADDR;
            next_s.bits = 4'h0;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.gc = 1'b0;
        end else if (stop_c) begin
            next_s.st = S_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.hit = 1'b0;
            next_s.gc = 1'b0;
        end else begin
            case (s.st)
                S_ADDR, S_ADDR2, S_RX: begin
                    if (rise) begin
                        next_s.sh = {s.sh[6:0], line.sda};
                        next_s.bits = s.bits + 4'h1;
                    end
                    if (fall && s.bits == `TW_LAST_BIT) begin
                        next_s.bits = 4'h0;
                        next_s.st = S_ACK;
                        next_s.sda_oe = 1'b1;
                        next_s.nxt = S_RX;
                        if (s.st == S_RX) begin
                            next_s.rx_valid = 1'b1;
                            next_s.rx_data = s.sh;
                        end else if (s.st == S_ADDR2) begin
                            next_s.hit = amatch({cfg.addr[9:8], s.sh}, cfg.addr, cfg.mask);
                            if (!next_s.hit) begin
                                next_s.st = S_IDLE;
                                next_s.sda_oe = 1'b0;
                            end
                        end else if (cfg.repeater || m7 || gc) begin // see (RULE7)
                            next_s.hit = 1'b1;
                            next_s.gc = gc;
                            next_s.nxt = s.sh[0] ? S_LOAD : S_RX;
                        end else if (hdr && !s.sh[0]) begin
                            next_s.hit = 1'b0;
                            next_s.nxt = S_ADDR2;
                        end else if (hdr && s.hit) begin
                            next_s.nxt = S_LOAD;
                        end else begin
                            next_s.st = S_IDLE;
                            next_s.sda_oe = 1'b0;
                        end
                    end
                end
                S_ACK: begin
                    if (fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = s.nxt;
                        next_s.scl_oe = (s.nxt == S_LOAD); // see (RULE4)
                    end
                end
                S_LOAD: begin
                    // clock stays held until the processor hands over a byte
                    if (tx_valid) begin
                        next_s.sh = tx_data;
                        next_s.sda_oe = ~tx_data[7];
                        next_s.scl_oe = 1'b0;
                        next_s.bits = 4'h0;
                        next_s.st = S_TX;
                    end
                end
                S_TX: begin
                    if (fall && s.bits == `TW_TX_LAST) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st = S_RACK;
                    end else if (fall) begin
                        next_s.sh = {s.sh[6:0], 1'b0};
                        next_s.sda_oe = ~s.sh[6];
                        next_s.bits = s.bits + 4'h1;
                    end
                end
                S_RACK: begin
                    if (rise) begin
                        next_s.nk = line.sda;
                    end
                    if (fall) begin
                        next_s.st = s.nk ? S_IDLE : S_LOAD;
                        next_s.scl_oe = !s.nk;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.pscl <= 1'b1;
            s.psda <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign tx_ready = (s.st == S_LOAD);
    assign rx_valid = s.rx_valid;
    assign rx_data = s.rx_data;
    assign addressed = s.hit;
    assign general_call = s.gc;
    assign scl_oe = s.scl_oe;
    assign sda_oe = s.sda_oe;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_stretch_hold: assert property ( // see (RULE4)
        s.st == S_LOAD && !tx_valid |=> s.st == S_LOAD && s.scl_oe)
        else $error("slave released clock with no data");
    chk_gen_call: assert property ( // see (RULE3)
        fall && s.st == S_ADDR && s.bits == 4'h8 && s.sh == 8'h00 && cfg.gc_en
        |=> s.st == S_ACK && s.sda_oe && s.gc)
        else $error("general call not acknowledged");
    chk_repeater_take: assert property ( // see (RULE7)
        fall && s.st == S_ADDR && s.bits == 4'h8 && cfg.repeater
        |=> s.st == S_ACK && s.hit)
        else $error("repeater mode refused a message");
    chk_mask_addr: assert property ( // see (RULE16)
        fall && s.st == S_ADDR && s.bits == 4'h8 && m7 |=> s.sda_oe ##1 s.st == S_ACK)
        else $error("masked address match not acknowledged");
endmodule
`default_nettype wire

// ==== bench/tw_far.sv ====
// far-side target on the two-wire bus: acks its own address, answers reads
// assumes resolved wired-and lines with pull-ups; drives only the data line
`timescale 1ns/1ps
`default_nettype none
module tw_far #(
    parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] RD   = 8'hA5
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_oe
);
    int         n = -1;
    logic [7:0] sh = 8'h00;
    logic       act = 1'b0;
    logic       first = 1'b1;
    logic       hit = 1'b0;
    logic       rd = 1'b0;
    initial sda_oe = 1'b0;
    // start and repeated start restart the frame
    always @(negedge sda) if (scl) begin
        act = 1'b1;
        n = -1;
        first = 1'b1;
        hit = 1'b0;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act && n >= 0 && n < 8) sh = {sh[6:0], sda};
    // changes only while the clock is low, so data holds across the high phase
    always @(negedge scl) if (act) begin
        if (n == 8) begin
            n = 0;
            first = 1'b0;
        end else n = n + 1;
        if (n == 8 && first) begin
            hit = (sh[7:1] == ADDR);
            rd = sh[0];
        end
        if (n == 8) sda_oe = hit && (first || !rd);
        else sda_oe = hit && rd && !first && (n >= 0) && !RD[7-n];
    end
endmodule
`default_nettype wire

// ==== bench/tw_port_test.sv ====
// bench for the two-wire port: master commands, far target, own slave
// assumes the bus sits on the alternate pins, primary pins idle high
`timescale 1ns/1ps
`default_nettype none
module tw_port_test
    import tw_pkg::*;
;
    logic       clk = 0, rst_n = 0, cmd_valid = 0, pri_used = 0, jam = 0, fast = 1, tx_valid = 0;
    logic       cmd_ready, rsp_valid, bus_owned, rx_valid, addressed, general_call, tx_ready;
    logic       scl_oe, sda_oe, p_scl_oe, p_sda_oe, far_oe;
    logic [7:0] rx_data, last_rx = 8'h00;
    logic [7:0] abyte [6] = '{8'h78, 8'h00, 8'hE4, 8'h7E, 8'h79, 8'hF0};
    tw_req_t    cmd = '0;
    tw_scfg_t   scfg = '{addr: 10'h03C, mask: 10'h000, ten: 1'b0, gc_en: 1'b1, repeater: 1'b0};
    tw_rsp_t    rsp, r;
    int         failures = 0, total_checks = 0, cycles = 0;
    wire        scl = !scl_oe;
    wire        sda = !(sda_oe || far_oe || jam);
    always #25 clk = ~clk;
    tw_port DUT (.clk(clk), .rst_n(rst_n), .alt_pin_route_bit(1'b0),
        .pri_scl_in(1'b1), .pri_scl_out(), .pri_scl_oe(p_scl_oe),
        .pri_sda_in(1'b1), .pri_sda_out(), .pri_sda_oe(p_sda_oe),
        .alt_serial_clock_pin_in(scl), .alt_serial_clock_pin_out(),
        .alt_serial_clock_pin_oe(scl_oe), .alt_serial_data_pin_in(sda),
        .alt_serial_data_pin_out(), .alt_serial_data_pin_oe(sda_oe), .fast_mode(fast),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp(rsp), .bus_owned(bus_owned), .scfg(scfg), .tx_valid(tx_valid), .tx_data(8'hC3),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .addressed(addressed),
        .general_call(general_call));
    tw_far far (.scl(scl), .sda(sda), .sda_oe(far_oe));
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(tw_cmd_t o, logic [7:0] d, logic nk);
        @(posedge clk);
        cmd <= '{op: o, data: d, nack: nk};
        cmd_valid <= 1'b1;
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1) @(posedge clk);
        r = rsp;
        repeat (2) @(negedge clk);
    endtask
    // ceiling well above the ~10k cycles the tests need, one of them at the standard rate
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rx_valid === 1'b1) last_rx <= rx_data;
        if (p_scl_oe !== 1'b0 || p_sda_oe !== 1'b0) pri_used <= 1'b1;
        if (cycles == 60000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        op(C_WRITE, 8'h55, 1'b0);
        chk("refused nack", 8'h01, {7'h00, r.nack});
        $display("test refused done");
        op(C_START, 8'h00, 1'b0);
        chk("bus owned", 8'h01, {7'h00, bus_owned});
        op(C_WRITE, 8'hA0, 1'b0);
        chk("write addr ack", 8'h00, {7'h00, r.nack});
        op(C_WRITE, 8'h3C, 1'b0);
        chk("data ack", 8'h00, {7'h00, r.nack});
        op(C_START, 8'h00, 1'b0);
        op(C_WRITE, 8'hA1, 1'b0);
        chk("read addr ack", 8'h00, {7'h00, r.nack});
        op(C_READ, 8'h00, 1'b1);
        chk("read data", 8'hA5, r.data);
        op(C_STOP, 8'h00, 1'b0);
        chk("bus released", 8'h00, {7'h00, bus_owned});
        op(C_START, 8'h00, 1'b0);
        @(posedge clk);
        jam <= 1'b1;
        op(C_WRITE, 8'hFF, 1'b0);
        chk("arb lost", 8'h01, {7'h00, r.arb_lost});
        @(posedge clk);
        jam <= 1'b0;
        $display("test far target done");
        // own address, general call, repeater, masked address
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            scfg.repeater <= (i == 2);
            scfg.mask <= (i == 3) ? 10'h003 : 10'h000;
            scfg.ten <= (i == 5);
            fast <= (i != 3);
            op(C_START, 8'h00, 1'b0);
            op(C_WRITE, abyte[i], 1'b0);
            if (i == 5) op(C_WRITE, 8'h3C, 1'b0);
            chk("slave ack", 8'h00, {7'h00, r.nack});
            chk("match", 8'h01, {7'h00, (i == 1) ? general_call : addressed});
            if (i == 0) op(C_WRITE, 8'h5A, 1'b0);
            if (i == 0) chk("rx byte", 8'h5A, last_rx);
            if (i == 4) begin
                repeat (4) @(posedge clk);
                chk("stretch", 8'h01, {7'h00, tx_ready});
                tx_valid <= 1'b1;
                @(posedge clk);
                tx_valid <= 1'b0;
                op(C_READ, 8'h00, 1'b1);
                chk("tx byte", 8'hC3, r.data);
            end
            op(C_STOP, 8'h00, 1'b0);
        end
        $display("test slave address done");
        chk("primary idle", 8'h00, {7'h00, pri_used});
        end_of_test();
    end
endmodule
`default_nettype wire
